/* hw/ext_bus_pkg.sv */
// ext_bus_pkg: constants, carrier types and shared decoding for the
// external bus cycle sequencer. Assumes one system clock, synchronous
// inputs and a word address on the request.
// Summary of operation
// - select one: dram burst by address, late acknowledge
// - select zero: dma single dram accesses stay full
// - other dram accesses may still burst
// - areas 0 and 1 each selectable as burst rom
// - burst length 4, 8, 16 or 32 words
// - burst cycle lasts 1 to 8 states
// - only cpu reads burst in rom space
// - initial cycle uses basic timing, ignores extensions
// - waits only in initial cycle, never bursts
// - write ends burst, done as basic cycle
// - idle lasts one or two states
// - idle before read to a different area
// - idle before write following a read
// - idle before read following a write
// - idle insertion enabled out of reset
// - dram full read, other area: precharge only
// - ras down bursts still take idle cycles
// - dram idle enable clear: no idle after dram read
// - ras down needs both bits; row stays low
package ext_bus_pkg;

  localparam int AREA_W = 3;
  localparam int ADDR_W = 24;
  localparam int CNT_W  = 5;

  localparam logic [AREA_W-1:0] ROM_AREA0 = 3'h0;
  localparam logic [AREA_W-1:0] ROM_AREA1 = 3'h1;

  localparam int BLEN_MIN_WORDS  = 4; // length code 0
  localparam int DRAM_ROW_STATES = 2; // row phase before first column
  localparam int DRAM_COL_STATES = 2; // one column cycle of a dram burst

  localparam logic [1:0] IDLE_SHORT = 2'h1;
  localparam logic [1:0] IDLE_LONG  = 2'h2;

  typedef struct packed {
    logic       idle_length_sel;
    logic       write_after_read_idle_en;
    logic       diff_area_read_idle_en;
    logic       read_after_write_idle_en;
    logic       dram_idle_en;
    logic       ras_down_sel;
    logic       dram_burst_en;
    logic       dma_ack_timing_sel;
    logic       area0_burst_rom_sel;
    logic       area1_burst_rom_sel;
    logic [1:0] area0_burst_len;
    logic [1:0] area1_burst_len;
    logic [2:0] area0_burst_cycle;
    logic [2:0] area1_burst_cycle;
  } cfg_t;

  // all three idle enables set, everything else clear
  localparam cfg_t CFG_RESET = 20'h70000;

  typedef struct packed {
    logic [AREA_W-1:0] area;
    logic [ADDR_W-1:0] addr;
    logic              is_write;
    logic              is_cpu;
    logic              dma_single;
    logic              is_dram;
    logic              row_hit;
  } req_t;

  typedef struct packed {
    logic              valid;
    logic [AREA_W-1:0] area;
    logic              was_write;
    logic              was_dram;
  } hist_t;

  function automatic logic rom_area(cfg_t c, logic [AREA_W-1:0] a);
    return (a == ROM_AREA0 && c.area0_burst_rom_sel) ||
           (a == ROM_AREA1 && c.area1_burst_rom_sel);
  endfunction : rom_area

  function automatic logic [1:0] rom_len(cfg_t c, logic [AREA_W-1:0] a);
    return (a == ROM_AREA1) ? c.area1_burst_len : c.area0_burst_len;
  endfunction : rom_len

  function automatic logic [2:0] rom_cycle(cfg_t c, logic [AREA_W-1:0] a);
    return (a == ROM_AREA1) ? c.area1_burst_cycle : c.area0_burst_cycle;
  endfunction : rom_cycle

endpackage : ext_bus_pkg

/* hw/idle_decide.sv */
// idle_decide: works out how many idle states go in front of the next
// external access, from the previous access and the configuration.
// Assumes the history record is that of the last finished access.
`timescale 1ns/1ps
`default_nettype none
module idle_decide
  import ext_bus_pkg::*;
(
  input  wire cfg_t   cfg_in,        // live configuration
  input  wire hist_t  hist_in,       // previous access
  input  wire req_t   req_in,        // next access
  input  wire logic   dram_burst_in, // next access is a dram burst
  output logic [1:0]  idle_n_out,    // idle states to insert
  output logic        pre_out        // precharge state only
);

  logic [1:0] n;
  logic       prev_rd;
  logic       diff;
  logic       war;
  logic       raw;

  // the three cases of idle insertion with their own enables
  always_comb begin
    n       = cfg_in.idle_length_sel ? IDLE_LONG : IDLE_SHORT;
    prev_rd = hist_in.valid & ~hist_in.was_write;
    diff    = prev_rd & ~req_in.is_write & (req_in.area != hist_in.area)
              & cfg_in.diff_area_read_idle_en;
    war     = prev_rd & req_in.is_write & cfg_in.write_after_read_idle_en;
    raw     = hist_in.valid & hist_in.was_write & ~req_in.is_write
              & cfg_in.read_after_write_idle_en;
    // read after write ignores the dram enable on purpose
    if (hist_in.was_dram && !cfg_in.dram_idle_en) begin
      diff = 1'b0;
      war  = 1'b0;
    end
    pre_out = 1'b0;
    // a full dram read already gets its precharge; ras down bursts do not
    if (diff && !hist_in.was_dram && req_in.is_dram && !dram_burst_in) begin
      diff    = 1'b0;
      pre_out = 1'b1;
    end
    idle_n_out = (diff | war | raw) ? n : 2'h0;
  end

endmodule : idle_decide
`default_nettype wire

/* hw/rom_burst_track.sv */
// rom_burst_track: remembers where a burst rom read sequence stands and
// says whether the next read may continue it as a burst cycle.
// Assumes launch_in pulses once per access as it starts.
`timescale 1ns/1ps
`default_nettype none
module rom_burst_track
  import ext_bus_pkg::*;
(
  input  wire logic clk_in,    // system clock
  input  wire logic rst_n_in,  // synchronised reset
  input  wire logic launch_in, // an access starts now
  input  wire req_t req_in,    // that access
  input  wire cfg_t cfg_in,    // live configuration
  output logic      hit_out,   // continue as burst cycle
  output logic      valid_out  // a burst is open
);

  logic              valid_q, valid_d;
  logic [AREA_W-1:0] area_q, area_d;
  logic [ADDR_W-1:0] next_q, next_d;
  logic [ADDR_W-1:0] mask;
  logic              rom;
  logic              cpu_rd;

  // next value of the open burst, and the hit decision
  always_comb begin
    rom     = rom_area(cfg_in, req_in.area);
    cpu_rd  = req_in.is_cpu & ~req_in.is_write;
    mask    = ADDR_W'((BLEN_MIN_WORDS << rom_len(cfg_in, req_in.area)) - 1);
    hit_out = valid_q & rom & cpu_rd & (req_in.area == area_q)
              & (req_in.addr == next_q);
    valid_d = valid_q;
    area_d  = area_q;
    next_d  = next_q;
    if (launch_in && rom) begin
      if (cpu_rd) begin
        // stepping past the aligned block closes it: next one starts full
        next_d  = req_in.addr + ADDR_W'(1);
        valid_d = (next_d & mask) != '0;
        area_d  = req_in.area;
      end else begin
        valid_d = 1'b0;
      end
    end
    valid_out = valid_q;
  end

  // state registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_q <= 1'b0;
      area_q  <= '0;
      next_q  <= '0;
    end else begin
      valid_q <= valid_d;
      area_q  <= area_d;
      next_q  <= next_d;
    end
  end

endmodule : rom_burst_track
`default_nettype wire

/* hw/ext_bus_seq.sv */
// ext_bus_seq: sequences one external access at a time through idle,
// precharge, initial (full) and burst states, and drives the dma
// acknowledge and the row strobe hold. Assumes requests and the wait
// pin are synchronous to clk_in; cfg_in is taken on cfg_load_in.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_seq
  import ext_bus_pkg::*;
(
  input  wire logic       clk_in,                // 100 MHz system clock
  input  wire logic       rst_n_in,              // async reset, active low
  input  wire cfg_t       cfg_in,                // new configuration
  input  wire logic       cfg_load_in,           // take cfg_in
  input  wire logic       req_valid_in,          // access request
  input  wire req_t       req_in,                // access description
  input  wire logic [3:0] full_states_in,        // basic cycle states, 1..15
  input  wire logic [2:0] prog_wait_in,          // program wait states
  input  wire logic       wait_n_in,             // wait pin, low holds
  input  wire logic       read_strobe_timing_in, // late read strobe setting
  input  wire logic       cs_extension_in,       // chip select extension
  output logic            req_ready_out,         // request taken when high
  output logic            idle_state_out,        // idle state
  output logic            precharge_out,         // precharge state
  output logic            full_access_out,       // initial full access
  output logic            burst_cycle_out,       // burst cycle
  output logic            done_out,              // access ended, pulse
  output logic            dma_acknowledge_n_out, // dma acknowledge, low
  output logic            ras_held_low_out,      // row strobe kept low
  output logic            read_strobe_late_out,  // late strobe applied
  output logic            cs_extend_out          // cs extension applied
);

  typedef enum logic [4:0] {
    ST_READY = 5'h01,
    ST_IDLE  = 5'h02,
    ST_PRE   = 5'h04,
    ST_FULL  = 5'h08,
    ST_BURST = 5'h10
  } state_t;

  // reset release through two flops; assertion is still immediate
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  state_t             state_q, state_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic [CNT_W-1:0]   el_q, el_d;
  req_t               cur_q, cur_d;
  cfg_t               cfg_q, cfg_d;
  hist_t              hist_q, hist_d;
  logic               loaded_q, loaded_d;
  logic               row_open_q, row_open_d;
  logic               out_idle_d, out_pre_d, out_full_d, out_burst_d;
  logic               done_d, ack_n_d, ras_d, rs_late_d, cs_ext_d;
  req_t               lreq;
  logic               launch;
  logic               dburst;
  logic               ras_mode;
  logic               dma_on;
  logic               ack_late;
  logic [1:0]         idle_n;
  logic               pre;
  logic               trk_hit;
  logic               trk_valid;

  idle_decide u_idle (
    .cfg_in        (cfg_q),
    .hist_in       (hist_q),
    .req_in        (req_in),
    .dram_burst_in (dburst),
    .idle_n_out    (idle_n),
    .pre_out       (pre)
  );

  rom_burst_track u_trk (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n),
    .launch_in (launch),
    .req_in    (lreq),
    .cfg_in    (cfg_q),
    .hit_out   (trk_hit),
    .valid_out (trk_valid)
  );

  // sequencing: choose the phase, count its states, record history
  always_comb begin
    lreq     = (state_q == ST_READY) ? req_in : cur_q;
    ras_mode = cfg_q.ras_down_sel & cfg_q.dram_burst_en;
    // dram burst: select one ignores the master, zero keeps dma full
    dburst   = cfg_q.dram_burst_en & lreq.is_dram & lreq.row_hit
               & (~lreq.dma_single | cfg_q.dma_ack_timing_sel);
    cfg_d    = cfg_load_in ? cfg_in : cfg_q;
    loaded_d = loaded_q | cfg_load_in;
    state_d  = state_q;
    cnt_d    = cnt_q;
    el_d     = el_q;
    cur_d    = cur_q;
    hist_d   = hist_q;
    done_d   = 1'b0;
    launch   = 1'b0;
    row_open_d = row_open_q & ras_mode;
    unique case (state_q)
      ST_READY: begin
        if (req_valid_in) begin
          cur_d = req_in;
          if (idle_n != 2'h0) begin
            state_d = ST_IDLE;
            cnt_d   = CNT_W'(idle_n - 2'h1);
          end else if (pre) begin
            state_d = ST_PRE;
          end else begin
            launch = 1'b1;
          end
        end
      end
      ST_IDLE: begin
        if (cnt_q == '0) begin
          launch = 1'b1;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_PRE: begin
        launch = 1'b1;
      end
      ST_FULL: begin
        el_d = el_q + CNT_W'(1);
        if (cnt_q != '0) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else if (wait_n_in) begin
          state_d = ST_READY;
          done_d  = 1'b1;
        end
      end
      ST_BURST: begin
        el_d = el_q + CNT_W'(1);
        if (cnt_q != '0) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else begin
          state_d = ST_READY;
          done_d  = 1'b1;
        end
      end
    endcase
    if (launch) begin
      el_d = '0;
      if (trk_hit) begin
        state_d = ST_BURST;
        cnt_d   = CNT_W'(rom_cycle(cfg_q, lreq.area));
      end else if (dburst) begin
        state_d = ST_BURST;
        cnt_d   = CNT_W'(DRAM_COL_STATES - 1);
      end else begin
        // initial access: basic state count plus program waits
        state_d = ST_FULL;
        cnt_d   = CNT_W'(full_states_in) + CNT_W'(prog_wait_in)
                  - CNT_W'(1);
      end
    end
    if (done_d) begin
      hist_d = '{valid: 1'b1, area: cur_q.area, was_write: cur_q.is_write,
                 was_dram: cur_q.is_dram};
      row_open_d = ras_mode & (cur_q.is_dram | row_open_q);
    end
  end

  // output values, all computed for the state being entered
  always_comb begin
    out_idle_d  = state_d == ST_IDLE;
    out_pre_d   = state_d == ST_PRE;
    out_full_d  = state_d == ST_FULL;
    out_burst_d = state_d == ST_BURST;
    dma_on      = cur_d.dma_single & (out_full_d | out_burst_d);
    // select one holds the acknowledge off through the row phase
    ack_late    = cur_d.is_dram & cfg_q.dma_ack_timing_sel & out_full_d
                  & (el_d < CNT_W'(DRAM_ROW_STATES));
    ack_n_d     = ~(dma_on & ~ack_late);
    ras_d       = ras_mode & row_open_d;
    // burst rom areas run the basic timing only
    rs_late_d   = read_strobe_timing_in & out_full_d
                  & ~rom_area(cfg_q, cur_d.area);
    cs_ext_d    = cs_extension_in & out_full_d
                  & ~rom_area(cfg_q, cur_d.area);
  end

  // state and output registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q               <= ST_READY;
      cnt_q                 <= '0;
      el_q                  <= '0;
      cur_q                 <= '0;
      cfg_q                 <= CFG_RESET;
      hist_q                <= '0;
      loaded_q              <= 1'b0;
      row_open_q            <= 1'b0;
      req_ready_out         <= 1'b1;
      idle_state_out        <= 1'b0;
      precharge_out         <= 1'b0;
      full_access_out       <= 1'b0;
      burst_cycle_out       <= 1'b0;
      done_out              <= 1'b0;
      dma_acknowledge_n_out <= 1'b1;
      ras_held_low_out      <= 1'b0;
      read_strobe_late_out  <= 1'b0;
      cs_extend_out         <= 1'b0;
    end else begin
      state_q               <= state_d;
      cnt_q                 <= cnt_d;
      el_q                  <= el_d;
      cur_q                 <= cur_d;
      cfg_q                 <= cfg_d;
      hist_q                <= hist_d;
      loaded_q              <= loaded_d;
      row_open_q            <= row_open_d;
      req_ready_out         <= state_d == ST_READY;
      idle_state_out        <= out_idle_d;
      precharge_out         <= out_pre_d;
      full_access_out       <= out_full_d;
      burst_cycle_out       <= out_burst_d;
      done_out              <= done_d;
      dma_acknowledge_n_out <= ack_n_d;
      ras_held_low_out      <= ras_d;
      read_strobe_late_out  <= rs_late_d;
      cs_extend_out         <= cs_ext_d;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  ack_column_a: assert property (
    state_q == ST_FULL && cur_q.dma_single && cur_q.is_dram
    && cfg_q.dma_ack_timing_sel |-> dma_acknowledge_n_out == (el_q < 2))
    else $error("dma acknowledge not held to first column state");

  ack_row_a: assert property (
    state_q == ST_FULL && cur_q.dma_single && !cfg_q.dma_ack_timing_sel
    |-> !dma_acknowledge_n_out)
    else $error("dma acknowledge not low through the row phase");

  dma_no_burst_a: assert property (
    state_q == ST_BURST && cur_q.is_dram && cur_q.dma_single
    |-> cfg_q.dma_ack_timing_sel && cfg_q.dram_burst_en)
    else $error("dma single access made as a dram burst");

  rom_cpu_read_a: assert property (
    burst_cycle_out && !cur_q.is_dram |-> cur_q.is_cpu && !cur_q.is_write)
    else $error("non cpu-read access burst in rom space");

  burst_no_wait_a: assert property (
    state_q == ST_BURST && cnt_q != '0 && !wait_n_in
    |=> state_q == ST_BURST && cnt_q == $past(cnt_q) - 5'h01)
    else $error("wait pin stretched a burst cycle");

  write_ends_a: assert property (
    launch && lreq.is_write && rom_area(cfg_q, lreq.area)
    |=> !trk_valid && full_access_out)
    else $error("write to burst rom did not end the burst");

  idle_length_a: assert property (
    $rose(idle_state_out) |-> if (cfg_q.idle_length_sel)
      (idle_state_out ##1 idle_state_out ##1 !idle_state_out)
    else (idle_state_out ##1 !idle_state_out))
    else $error("idle state length wrong");

  reset_idle_a: assert property (
    !loaded_q |-> cfg_q == CFG_RESET)
    else $error("idle insertion not enabled after reset");

  dram_idle_off_a: assert property (
    req_ready_out && req_valid_in && hist_q.was_dram && !hist_q.was_write
    && !cfg_q.dram_idle_en |=> !idle_state_out)
    else $error("idle cycle inserted after dram read");

  ras_mode_a: assert property (
    ras_held_low_out |-> $past(ras_mode))
    else $error("row strobe held outside ras down mode");

  // reads of two normal areas in a row must be split by an idle state
  diff_idle_a: assert property (
    req_ready_out && req_valid_in && hist_q.valid && !hist_q.was_write
    && !hist_q.was_dram && !req_in.is_write && !req_in.is_dram
    && req_in.area != hist_q.area && cfg_q.diff_area_read_idle_en |=> idle_state_out)
    else $error("no idle state between reads of different areas");

  // the precharge state replaces the idle state, it never follows one
  pre_only_a: assert property (
    precharge_out |-> !idle_state_out && $past(req_ready_out))
    else $error("precharge state not taken in place of idle");

  cover_rom_burst: cover property (burst_cycle_out && !cur_q.is_dram);
  cover_idle_long: cover property (idle_state_out [*2]);
  cover_precharge: cover property (precharge_out ##1 full_access_out);
  cover_ack_late: cover property (dma_acknowledge_n_out ##1
    !dma_acknowledge_n_out && full_access_out && cur_q.is_dram);

endmodule : ext_bus_seq
`default_nettype wire

/* verification/wait_partner.sv */
// wait_partner: slow external device on the far side of the sequencer.
// Assumes phase outputs of the sequencer come straight from flops.
`timescale 1ns/1ps
`default_nettype none
module wait_partner (
  input  wire logic       clk_in,    // system clock
  input  wire logic       full_in,   // initial access state
  input  wire logic       burst_in,  // burst cycle state
  input  wire logic [4:0] states_in, // programmed initial states
  input  wire logic [2:0] stall_in,  // wait states to request
  output logic            wait_n_out // wait pin, pulled up when idle
);
  logic [5:0] cnt_q;
  logic [5:0] pos;
  // count states of the running initial access
  always_ff @(posedge clk_in) begin
    cnt_q <= full_in ? cnt_q + 6'h01 : 6'h00;
  end
  // low from the last state for stall_in cycles; bursts get it too,
  // which a careless device does and the sequencer must ignore
  assign pos        = cnt_q + 6'h01;
  assign wait_n_out = !((full_in && pos >= states_in && pos < states_in + stall_in)
                        || (burst_in && stall_in != 3'h0));
endmodule : wait_partner
`default_nettype wire

/* verification/ext_bus_burst_rom_idle_cycle_tb.sv */
// ext_bus_burst_rom_idle_cycle_tb: scenario tasks for the bus sequencer.
// Assumes the package, the design and wait_partner are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_burst_rom_idle_cycle_tb
  import ext_bus_pkg::*;
;
  localparam logic [4:0] CRD = 5'h08; // cpu read
  localparam logic [4:0] CWR = 5'h18; // cpu write
  localparam logic [4:0] NRD = 5'h00; // non-cpu read
  localparam logic [4:0] DHT = 5'h0B; // cpu dram read, row hit
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  cfg_t       cfg_in = CFG_RESET;
  logic       cfg_load_in = 1'b0;
  logic       req_valid_in = 1'b0;
  req_t       req_in = '0;
  logic [3:0] full_states_in = 4'h2;
  logic [2:0] prog_wait_in = 3'h0;
  logic [2:0] stall = 3'h0;
  logic       read_strobe_timing_in = 1'b1;
  logic       cs_extension_in = 1'b0;
  logic       wait_n_in;
  logic       ready, idle, pre, full, burst, done, ack_n, ras_held, late, ext;
  int         fail_count = 0;
  int         comparisons = 0;

  always #5 clk_in = ~clk_in;

  ext_bus_seq u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg_in),
    .cfg_load_in(cfg_load_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .full_states_in(full_states_in), .prog_wait_in(prog_wait_in), .wait_n_in(wait_n_in),
    .read_strobe_timing_in(read_strobe_timing_in), .cs_extension_in(cs_extension_in),
    .req_ready_out(ready), .idle_state_out(idle), .precharge_out(pre),
    .full_access_out(full), .burst_cycle_out(burst), .done_out(done),
    .dma_acknowledge_n_out(ack_n), .ras_held_low_out(ras_held),
    .read_strobe_late_out(late), .cs_extend_out(ext));

  wait_partner u_partner (.clk_in(clk_in), .full_in(full), .burst_in(burst),
    .states_in({1'b0, full_states_in} + {2'b0, prog_wait_in}), .stall_in(stall),
    .wait_n_out(wait_n_in));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  function automatic req_t mk(input logic [2:0] a, input logic [23:0] d, input logic [4:0] f);
    return {a, d, f};
  endfunction : mk

  // config goes in only with the load strobe, so pulse it for one edge
  task automatic set_cfg(input cfg_t c);
    @(posedge clk_in);
    cfg_in      <= c;
    cfg_load_in <= 1'b1;
    @(posedge clk_in);
    cfg_load_in <= 1'b0;
  endtask : set_cfg

  // one access: counts each phase until done, then compares the counts
  task automatic access(input req_t r, input logic [7:0] ei, ep, ef, eb, ed, ex);
    logic [7:0] ni, np, nf, nb, nd, nx, nr;
    int         k;
    {ni, np, nf, nb, nd, nx, nr} = '0;
    @(posedge clk_in);
    req_in       <= r;
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    for (k = 0; k < 100; k++) begin
      #1;
      if (done === 1'b1) break;
      ni = ni + idle;
      np = np + pre;
      nf = nf + full;
      nb = nb + burst;
      nd = nd + !ack_n;
      nx = nx + (full & (late | ext));
      nr = nr + ready;
      @(posedge clk_in);
    end
    check("done", done, 8'h01);
    check("ready at done", ready, 8'h01);
    check("ready during access", nr, 8'h00);
    check("idle states", ni, ei);
    check("precharge states", np, ep);
    check("full states", nf, ef);
    check("burst states", nb, eb);
    check("dma acknowledge states", nd, ed);
    check("strobe and cs extension states", nx, ex);
  endtask : access

  // default config straight out of reset, short idle
  task automatic t_idle_reset();
    access(mk(3'h2, 24'h10, CRD), 0, 0, 2, 0, 0, 2);
    access(mk(3'h3, 24'h20, CRD), 1, 0, 2, 0, 0, 2);
    access(mk(3'h3, 24'h21, CWR), 1, 0, 2, 0, 0, 2);
    access(mk(3'h3, 24'h22, CRD), 1, 0, 2, 0, 0, 2);
    access(mk(3'h3, 24'h23, CRD), 0, 0, 2, 0, 0, 2);
  endtask : t_idle_reset

  // long idle, only the different-area enable kept
  task automatic t_idle_len();
    cfg_t c;
    c = '0;
    c.idle_length_sel = 1'b1;
    c.diff_area_read_idle_en = 1'b1;
    set_cfg(c);
    access(mk(3'h2, 24'h30, CRD), 2, 0, 2, 0, 0, 2);
    access(mk(3'h2, 24'h31, CWR), 0, 0, 2, 0, 0, 2);
    access(mk(3'h2, 24'h32, CRD), 0, 0, 2, 0, 0, 2);
  endtask : t_idle_len

  // every length code, alternating areas, with a stalling device
  task automatic t_rom_burst();
    cfg_t        c;
    logic [2:0]  cy;
    logic [2:0]  a;
    logic [23:0] b;
    int          n;
    c = '0;
    c.area0_burst_rom_sel = 1'b1;
    c.area1_burst_rom_sel = 1'b1;
    cs_extension_in <= 1'b1;
    prog_wait_in    <= 3'h1;
    stall           <= 3'h2;
    for (int l = 0; l < 4; l++) begin
      cy = 3'h7 >> l;
      a = l[0] ? ROM_AREA1 : ROM_AREA0;
      n = BLEN_MIN_WORDS << l;
      b = 24'(256 * (l + 1));
      c.area0_burst_len = 2'(l);
      c.area1_burst_len = 2'(l);
      c.area0_burst_cycle = cy;
      c.area1_burst_cycle = cy;
      set_cfg(c);
      access(mk(a, b, CRD), 0, 0, 5, 0, 0, 0);
      for (int k = 1; k < n; k++) begin
        access(mk(a, 24'(b + k), CRD), 0, 0, 0, 8'(cy + 1), 0, 0);
      end
      access(mk(a, 24'(b + n), CRD), 0, 0, 5, 0, 0, 0);
    end
    prog_wait_in <= 3'h0;
    stall        <= 3'h0;
  endtask : t_rom_burst

  // a write and a non-cpu read break the burst; area 1 left ordinary
  task automatic t_rom_break();
    cfg_t c;
    c = '0;
    c.area0_burst_rom_sel = 1'b1;
    c.area0_burst_len = 2'h3;
    set_cfg(c);
    access(mk(ROM_AREA0, 24'h400, CRD), 0, 0, 2, 0, 0, 0);
    access(mk(ROM_AREA0, 24'h401, CRD), 0, 0, 0, 1, 0, 0);
    access(mk(ROM_AREA0, 24'h402, CWR), 0, 0, 2, 0, 0, 0);
    access(mk(ROM_AREA0, 24'h403, CRD), 0, 0, 2, 0, 0, 0);
    access(mk(ROM_AREA0, 24'h404, NRD), 0, 0, 2, 0, 0, 0);
    access(mk(ROM_AREA0, 24'h405, CRD), 0, 0, 2, 0, 0, 0);
    access(mk(ROM_AREA1, 24'h406, CRD), 0, 0, 2, 0, 0, 2);
    access(mk(ROM_AREA1, 24'h407, CRD), 0, 0, 2, 0, 0, 2);
  endtask : t_rom_break

  // dma single transfers against dram under both acknowledge timings
  task automatic t_dram_dma_acknowledge_n();
    cfg_t c;
    c = '0;
    c.dram_burst_en = 1'b1;
    c.dma_ack_timing_sel = 1'b1;
    read_strobe_timing_in <= 1'b0;
    cs_extension_in       <= 1'b0;
    full_states_in        <= 4'h4;
    set_cfg(c);
    access(mk(3'h4, 24'h200, 5'h06), 0, 0, 4, 0, 4 - DRAM_ROW_STATES, 0);
    access(mk(3'h4, 24'h201, 5'h07), 0, 0, 0, DRAM_COL_STATES, DRAM_COL_STATES, 0);
    access(mk(3'h4, 24'h202, DHT), 0, 0, 0, DRAM_COL_STATES, 0, 0);
    c.dma_ack_timing_sel = 1'b0;
    set_cfg(c);
    access(mk(3'h4, 24'h203, 5'h07), 0, 0, 4, 0, 4, 0);
    access(mk(3'h4, 24'h204, DHT), 0, 0, 0, DRAM_COL_STATES, 0, 0);
  endtask : t_dram_dma_acknowledge_n

  // precharge-only, dram idle gate and the held row strobe
  task automatic t_dram_idle();
    cfg_t c;
    c = '0;
    c.diff_area_read_idle_en = 1'b1;
    c.dram_burst_en = 1'b1;
    c.ras_down_sel = 1'b1;
    set_cfg(c);
    access(mk(3'h2, 24'h300, CRD), 0, 0, 4, 0, 0, 0);
    access(mk(3'h4, 24'h301, 5'h0A), 0, 1, 4, 0, 0, 0);
    access(mk(3'h2, 24'h302, CRD), 0, 0, 4, 0, 0, 0);
    check("row strobe held", ras_held, 8'h01);
    access(mk(3'h4, 24'h303, DHT), 1, 0, 0, DRAM_COL_STATES, 0, 0);
    c.dram_idle_en = 1'b1;
    set_cfg(c);
    access(mk(3'h2, 24'h304, CRD), 1, 0, 4, 0, 0, 0);
    c.ras_down_sel = 1'b0;
    set_cfg(c);
    repeat (2) @(posedge clk_in);
    #1;
    check("row strobe held", ras_held, 8'h00);
  endtask : t_dram_idle

  // main sequence: reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    t_idle_reset();
    t_idle_len();
    t_rom_burst();
    t_rom_break();
    t_dram_dma_acknowledge_n();
    t_dram_idle();
    summarize();
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule : ext_bus_burst_rom_idle_cycle_tb
`default_nettype wire
